// ### rtl/p8t_timer.sv
// top: prescaled 8-bit auto-reload overflow timer with register port and interrupt
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module p8t_timer
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sys_tick,
    input wire logic sub_tick,
    input wire logic power_down,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic overflow_pulse,
    output logic wake_req
);
    import p8t_pkg::*;
    // ==========================================================
    // state
    typedef enum logic [1:0] {
        P8T_IDLE = 2'b01,
        P8T_RUN = 2'b10
    } p8t_mode_t;
    typedef struct packed {
        p8t_mode_t mode;
        logic [7:0] count;
        logic [7:0] preload;
        p8t_cfg_t cfg;
        logic [7:0] rdata;
        logic ovf;
        logic wake;
    } p8t_state_t;
    p8t_state_t s_q;
    p8t_state_t s_d;
    p8t_bus_req_t req;
    logic tick;
    logic blocked;
    logic wr_count;
    logic wr_ctrl;
    logic clr_wr;
    logic msk_wr;
    logic stat_bit;
    logic mask_bit;
    logic irq_w;
    logic wrap;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    // ==========================================================
    // address decode
    assign wr_count = req.wr && req.addr == P8T_ADDR_COUNT;
    assign wr_ctrl = req.wr && req.addr == P8T_ADDR_CTRL;
    assign clr_wr = req.wr && req.addr == P8T_ADDR_IRQ_STAT;
    assign msk_wr = req.wr && req.addr == P8T_ADDR_IRQ_MASK;
    // counting pulse is held off during a counter read or preload write
    assign blocked = wr_count || (req.rd && req.addr == P8T_ADDR_COUNT);
    // ==========================================================
    // prescaler
    p8t_prescaler #(.PSC_W(P8T_CTRL_PSC_W)) u_psc
    (
        .core_clk(core_clk),
        .rst(rst),
        .sys_tick(sys_tick),
        .sub_tick(sub_tick),
        .src_sel(s_q.cfg.src_sel),
        .run(s_q.cfg.count_en),
        .psc_sel(s_q.cfg.psc_sel),
        .tick(tick)
    );
    assign wrap = s_q.cfg.count_en && tick && !blocked && s_q.count == P8T_FULL_COUNT;
    // ==========================================================
    // counter, preload, control and read mux
    always_comb
    begin
        s_d = s_q;
        s_d.ovf = 1'b0;
        s_d.rdata = 8'h00;
        if (wr_count)
        begin
            s_d.preload = req.wdata;
            if (!s_q.cfg.count_en)
                s_d.count = req.wdata;
        end
        if (wr_ctrl)
        begin
            s_d.cfg.src_sel = req.wdata[P8T_CTRL_SRC_BIT];
            s_d.cfg.count_en = req.wdata[P8T_CTRL_EN_BIT];
            s_d.cfg.psc_sel = req.wdata[P8T_CTRL_PSC_LSB +: P8T_CTRL_PSC_W];
        end
        s_d.mode = s_d.cfg.count_en ? P8T_RUN : P8T_IDLE;
        unique case (s_q.mode)
            P8T_RUN:
            begin
                // the blocked pulse is simply lost; software accepts that error
                if (tick && !blocked)
                begin
                    if (wrap)
                    begin
                        s_d.count = s_q.preload;
                        s_d.ovf = 1'b1;
                    end
                    else
                        s_d.count = s_q.count + 8'h01;
                end
            end
            P8T_IDLE:
            begin
                // count held unless the preload is written
            end
        endcase
        s_d.wake = power_down && s_d.ovf;
        if (req.rd)
        begin
            unique case (req.addr)
                P8T_ADDR_COUNT: s_d.rdata = s_q.count;
                P8T_ADDR_CTRL: s_d.rdata = {2'b00, s_q.cfg.src_sel, s_q.cfg.count_en, 1'b0, s_q.cfg.psc_sel};
                P8T_ADDR_IRQ_STAT: s_d.rdata = {7'h00, stat_bit};
                P8T_ADDR_IRQ_MASK: s_d.rdata = {7'h00, mask_bit};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end
    // ==========================================================
    // interrupt
    p8t_irq u_irq
    (
        .core_clk(core_clk),
        .rst(rst),
        .event_in(s_q.ovf),
        .stat_clr_wr(clr_wr),
        .mask_wr(msk_wr),
        .wbit(req.wdata[0]),
        .stat(stat_bit),
        .mask(mask_bit),
        .irq(irq_w)
    );
    // registers; counter given a known value though software should still preload it
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q.mode <= P8T_IDLE;
            s_q.count <= P8T_COUNT_RST;
            s_q.preload <= P8T_COUNT_RST;
            s_q.cfg <= '{src_sel: P8T_CTRL_RST[P8T_CTRL_SRC_BIT], count_en: P8T_CTRL_RST[P8T_CTRL_EN_BIT],
                psc_sel: P8T_CTRL_RST[P8T_CTRL_PSC_LSB +: P8T_CTRL_PSC_W]};
            s_q.rdata <= 8'h00;
            s_q.ovf <= 1'b0;
            s_q.wake <= 1'b0;
        end
        else
            s_q <= s_d;
    end
    assign reg_rdata = s_q.rdata;
    assign overflow_pulse = s_q.ovf;
    assign wake_req = s_q.wake;
    assign irq = irq_w;
    // ==========================================================
    // checks
    inc_one_a: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.mode == P8T_RUN && tick && !blocked && s_q.count != 8'hFF) |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step by one");
    reload_ovf_a: assert property (@(posedge core_clk) disable iff (rst)
        wrap |=> (overflow_pulse && s_q.count == $past(s_q.preload)))
        else $error("overflow did not reload");
    auto_reload_a: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.mode == P8T_RUN && s_q.count == 8'hFF && tick && !blocked && !wr_count) |=> s_q.count == $past(s_q.preload))
        else $error("reload value wrong");
    off_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_count && !s_q.cfg.count_en) |=> s_q.count == $past(reg_wdata))
        else $error("stopped write missed the counter");
    on_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_count && s_q.cfg.count_en) |=> (s_q.preload == $past(reg_wdata) && s_q.count == $past(s_q.count)))
        else $error("running write reached the counter");
    hold_off_a: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.mode == P8T_IDLE && !wr_count) |=> $stable(s_q.count))
        else $error("stopped counter moved");
    read_live_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == P8T_ADDR_COUNT) |=> reg_rdata == $past(s_q.count))
        else $error("read did not return counter");
    block_tick_a: assert property (@(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == P8T_ADDR_COUNT) |=> $stable(s_q.count))
        else $error("counter moved during read");
    wake_any_a: assert property (@(posedge core_clk) disable iff (rst)
        (wrap && power_down) |=> wake_req)
        else $error("no wake on overflow in power-down");
    en_bit_a: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> s_q.cfg.count_en == $past(reg_wdata[4]))
        else $error("enable bit not taken");
    ovf_cov: cover property (@(posedge core_clk) disable iff (rst) wrap);
    irq_cov: cover property (@(posedge core_clk) disable iff (rst) irq);
    wake_cov: cover property (@(posedge core_clk) disable iff (rst) wake_req);
    late_load_cov: cover property (@(posedge core_clk) disable iff (rst) (wr_count && s_q.cfg.count_en) ##[1:300] wrap);
endmodule
`default_nettype wire

// ### rtl/p8t_pkg.sv
// package: register map, field layout, reset values and carriers of the prescaled 8-bit timer
// Notes on behaviour
// - the timer input clock is the system clock when the source select bit is 0 and the sub oscillator when it is 1.
// - the 3-bit prescale field divides the selected clock by 2 to the power of its code, 1 up to 128.
// - the 8-bit counter goes up by exactly one on each prescaled pulse while counting is enabled.
// - the counter runs from the preload value up to FFH and overflows on the next pulse after FFH.
// - at overflow the counter takes the current preload value and keeps counting with no software help.
// - a preload write while counting is off goes into the counter at once as well.
// - a preload write while counting is on waits in the preload register until the next overflow.
// - bit 4 of the control register lets the counter run when set and stops it when clear.
// - reading the timer register returns the live counter, not the preload.
// - while software reads the counter or writes the preload, the counting pulse is blocked, which may lose a count.
// - each overflow sets the timer interrupt request flag.
// - an overflow becomes an interrupt only while the timer interrupt enable bit is set.
// - in power-down an overflow raises a wake-up request whether or not the interrupt is enabled.
package p8t_pkg;
    // ==========================================================
    // register map (byte addresses on the plain register port)
    localparam logic [3:0] P8T_ADDR_COUNT = 4'h0;
    localparam logic [3:0] P8T_ADDR_CTRL = 4'h4;
    localparam logic [3:0] P8T_ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] P8T_ADDR_IRQ_MASK = 4'hC;
    // ==========================================================
    // control field positions
    localparam int P8T_CTRL_PSC_LSB = 0;
    localparam int P8T_CTRL_PSC_W = 3;
    localparam int P8T_CTRL_EN_BIT = 4;
    localparam int P8T_CTRL_SRC_BIT = 5;
    localparam logic [7:0] P8T_CTRL_WMASK = 8'h37;
    // ==========================================================
    // reset values and the full count
    localparam logic [7:0] P8T_CTRL_RST = 8'h00;
    localparam logic [7:0] P8T_COUNT_RST = 8'h00;
    localparam logic [7:0] P8T_FULL_COUNT = 8'hFF;
    localparam logic [0:0] P8T_IRQ_RST = 1'h0;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } p8t_bus_req_t;
    typedef struct packed {
        logic src_sel;
        logic count_en;
        logic [2:0] psc_sel;
    } p8t_cfg_t;
endpackage

// ### rtl/p8t_prescaler.sv
// prescaler: clock source pick and divide-by-2^n pulse generator
`timescale 1ns/1ps
`default_nettype none
module p8t_prescaler
#(
    parameter int PSC_W = 3
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sys_tick,
    input wire logic sub_tick,
    input wire logic src_sel,
    input wire logic run,
    input wire logic [PSC_W-1:0] psc_sel,
    output logic tick
);
    import p8t_pkg::*;
    localparam int DIV_W = (1 << PSC_W) - 1;
    typedef struct packed {
        logic [DIV_W-1:0] div;
    } p8t_psc_state_t;
    p8t_psc_state_t s_q;
    p8t_psc_state_t s_d;
    logic src_tick;
    logic [DIV_W:0] mask;
    // the selected source tick
    assign src_tick = src_sel ? sub_tick : sys_tick;
    // terminal mask: low psc_sel bits of the divider must be all ones
    assign mask = ({{DIV_W{1'b0}}, 1'b1} << psc_sel) - {{DIV_W{1'b0}}, 1'b1};
    // divider state: free-runs while enabled, cleared when stopped so each start is a full period
    always_comb
    begin
        s_d = s_q;
        if (!run)
            s_d.div = '0;
        else if (src_tick)
            s_d.div = s_q.div + {{(DIV_W-1){1'b0}}, 1'b1};
    end
    assign tick = run && src_tick && ((s_q.div & mask[DIV_W-1:0]) == mask[DIV_W-1:0]);
    always_ff @(posedge core_clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    // one pulse per 2^psc_sel source ticks
    psc_ratio_a: assert property (@(posedge core_clk) disable iff (rst)
        (tick && psc_sel != '0) |=> (!tick || !$stable(psc_sel)))
        else $error("prescaler pulsed twice in a row");
endmodule
`default_nettype wire

// ### rtl/p8t_irq.sv
// sticky interrupt status and mask, write one to clear
`timescale 1ns/1ps
`default_nettype none
module p8t_irq
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic event_in,
    input wire logic stat_clr_wr,
    input wire logic mask_wr,
    input wire logic wbit,
    output logic stat,
    output logic mask,
    output logic irq
);
    import p8t_pkg::*;
    typedef struct packed {
        logic stat;
        logic mask;
        logic irq;
    } p8t_irq_state_t;
    p8t_irq_state_t s_q;
    p8t_irq_state_t s_d;
    // set beats clear so an overflow in the clearing cycle is kept
    always_comb
    begin
        s_d = s_q;
        if (stat_clr_wr && wbit)
            s_d.stat = 1'b0;
        if (event_in)
            s_d.stat = 1'b1;
        if (mask_wr)
            s_d.mask = wbit;
        s_d.irq = s_d.stat && s_d.mask;
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            s_q <= {P8T_IRQ_RST, P8T_IRQ_RST, P8T_IRQ_RST};
        else
            s_q <= s_d;
    end
    assign stat = s_q.stat;
    assign mask = s_q.mask;
    assign irq = s_q.irq;
    irq_gated_a: assert property (@(posedge core_clk) disable iff (rst)
        irq |-> (stat && mask))
        else $error("interrupt high without enabled request");
    flag_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        event_in |=> stat)
        else $error("overflow did not set request flag");
    irq_raise_a: assert property (@(posedge core_clk) disable iff (rst)
        (event_in && mask && !mask_wr) |=> irq)
        else $error("enabled overflow raised no interrupt");
    stat_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (stat_clr_wr && wbit && !event_in) |=> !stat)
        else $error("write one did not clear request flag");
endmodule
`default_nettype wire

// ### dv/p8t_timer_tb.sv
// testbench: register-level checks of the prescaled 8-bit overflow timer
`timescale 1ns/1ps
`default_nettype none
module p8t_timer_tb;
    import p8t_pkg::*;
    // ==========================================================
    // stimulus signals and scoreboard counters
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sys_tick = 1'b0;
    logic sub_tick = 1'b0;
    logic power_down = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic overflow_pulse;
    logic wake_req;
    logic [7:0] v;
    int error_cnt = 0;
    int tests_run = 0;
    int ov_cnt = 0;
    int wk_cnt = 0;

    // 25 MHz core clock
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    p8t_timer u_p8t_timer
    (
        .core_clk(core_clk),
        .rst(rst),
        .sys_tick(sys_tick),
        .sub_tick(sub_tick),
        .power_down(power_down),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .irq(irq),
        .overflow_pulse(overflow_pulse),
        .wake_req(wake_req)
    );

    // pulses stand one cycle, so counting them avoids guessing their exact cycle
    always @(posedge core_clk)
    begin
        if (overflow_pulse === 1'b1)
            ov_cnt <= ov_cnt + 1;
        if (wake_req === 1'b1)
            wk_cnt <= wk_cnt + 1;
    end

    // ==========================================================
    // bus tasks and checks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // ns system ticks and nb sub oscillator ticks, one per cycle, then settle
    task automatic pulses(input int ns, input int nb);
        for (int i = 0; i < ns || i < nb; i++)
        begin
            @(posedge core_clk);
            sys_tick <= (i < ns);
            sub_tick <= (i < nb);
        end
        @(posedge core_clk);
        sys_tick <= 1'b0;
        sub_tick <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic wait_ov(input int n);
        int i;
        i = 0;
        while (ov_cnt < n && i < 64)
        begin
            @(posedge core_clk);
            i++;
        end
        if (ov_cnt < n)
        begin
            chk(ov_cnt[7:0], n[7:0]);
            print_verdict();
        end
        else
        begin
            // a surplus overflow here would mean the reload went wrong
            repeat (3) @(posedge core_clk);
            chk(ov_cnt[7:0], n[7:0]);
        end
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge core_clk);
        #1;
        chk({7'h00, irq}, {7'h00, e});
    endtask

    // hang guard: a stuck run ends as a mismatch
    initial
    begin
        repeat (30000) @(posedge core_clk);
        chk(8'h00, 8'h01);
        print_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // reset values, including an unmapped address
        rd(P8T_ADDR_COUNT, v);
        chk(v, P8T_COUNT_RST);
        rd(P8T_ADDR_CTRL, v);
        chk(v, P8T_CTRL_RST);
        rd(P8T_ADDR_IRQ_STAT, v);
        chk(v, 8'h00);
        rd(P8T_ADDR_IRQ_MASK, v);
        chk(v, 8'h00);
        rd(4'h2, v);
        chk(v, 8'h00);
        chk({7'h00, irq}, 8'h00);
        chk({6'h00, overflow_pulse, wake_req}, 8'h00);
        wr(P8T_ADDR_CTRL, 8'hFF);
        rd(P8T_ADDR_CTRL, v);
        chk(v, P8T_CTRL_WMASK);
        // read data stand one cycle only, then drop back to zero
        @(posedge core_clk);
        #1;
        chk(reg_rdata, 8'h00);
        wr(P8T_ADDR_CTRL, 8'h00);
        wr(4'h6, 8'hFF);
        rd(4'h6, v);
        chk(v, 8'h00);
        wr(P8T_ADDR_IRQ_MASK, 8'h01);
        rd(P8T_ADDR_IRQ_MASK, v);
        chk(v, 8'h01);
        $display("test registers done");
        // stopped counter takes a preload write at once and then holds
        wr(P8T_ADDR_COUNT, 8'h5A);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h5A);
        pulses(20, 20);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h5A);
        $display("test stopped done");
        // every prescale code with both sources; the unselected source ticks twice as many times
        for (int n = 0; n < 8; n++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                wr(P8T_ADDR_CTRL, 8'h00);
                wr(P8T_ADDR_COUNT, 8'h00);
                wr(P8T_ADDR_CTRL, {2'b00, s[0], 1'b1, 1'b0, n[2:0]});
                if (s == 0)
                    pulses(3 << n, 6 << n);
                else
                    pulses(6 << n, 3 << n);
                rd(P8T_ADDR_COUNT, v);
                chk(v, 8'h03);
            end
        end
        $display("test prescaler done");
        // a count read in mid-run swallows exactly one of eight ticks
        wr(P8T_ADDR_CTRL, 8'h00);
        wr(P8T_ADDR_COUNT, 8'h10);
        wr(P8T_ADDR_CTRL, 8'h10);
        @(posedge core_clk) sys_tick <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h14);
        repeat (3) @(posedge core_clk);
        sys_tick <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h17);
        // clearing the enable stops a running counter where it stands
        wr(P8T_ADDR_CTRL, 8'h00);
        pulses(4, 4);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h17);
        $display("test blocking done");
        // overflow with a preload written while running
        wr(P8T_ADDR_CTRL, 8'h00);
        wr(P8T_ADDR_COUNT, 8'hFD);
        wr(P8T_ADDR_CTRL, 8'h10);
        wr(P8T_ADDR_COUNT, 8'h80);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'hFD);
        pulses(3, 0);
        wait_ov(1);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h80);
        rd(P8T_ADDR_IRQ_STAT, v);
        chk(v, 8'h01);
        chk({7'h00, irq}, 8'h01);
        chk(wk_cnt[7:0], 8'h00);
        wr(P8T_ADDR_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        $display("test overflow done");
        // masked overflow in power-down still wakes, full 128-count period from 80
        wr(P8T_ADDR_IRQ_MASK, 8'h00);
        @(posedge core_clk) power_down <= 1'b1;
        pulses(128, 0);
        wait_ov(2);
        chk(wk_cnt[7:0], 8'h01);
        // the flag stays set after the wake; enabling the mask then raises the interrupt until a write of one clears the flag
        rd(P8T_ADDR_IRQ_STAT, v);
        chk(v, 8'h01);
        chk({7'h00, irq}, 8'h00);
        rd(P8T_ADDR_COUNT, v);
        chk(v, 8'h80);
        wr(P8T_ADDR_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        wr(P8T_ADDR_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        $display("test wakeup done");
        // a reset in mid-run clears the running control, the counter and the mask
        @(posedge core_clk);
        power_down <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(P8T_ADDR_COUNT, v);
        chk(v, P8T_COUNT_RST);
        rd(P8T_ADDR_CTRL, v);
        chk(v, P8T_CTRL_RST);
        rd(P8T_ADDR_IRQ_MASK, v);
        chk(v, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
